// >>> design/converter_ctl_pkg.sv
package converter_ctl_pkg;

    // ------------------------------------------------------------
    // Clock
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;

    // ------------------------------------------------------------
    // Register addresses and field positions
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] SYNC_ADDR = 4'hE;
    localparam int INTERLEAVE_BIT = 7;
    localparam int CAL_CMD_BIT = 15;
    localparam int REF_OUT_EN_BIT = 1;
    localparam int REF_DELAY_LSB = 4;
    localparam int REF_DELAY_W = 4;

    // ------------------------------------------------------------
    // Register defaults, used whenever pins govern the settings
    // ------------------------------------------------------------
    localparam logic [15:0] CTRL_DEFAULT = 16'h0000;
    localparam logic [15:0] SYNC_DEFAULT = 16'h0000;

    // ------------------------------------------------------------
    // Trigger timing: least times round up to whole cycles
    // ------------------------------------------------------------
    localparam int CAL_LOW_MIN_NS = 1000;
    localparam int CAL_HIGH_MIN_NS = 1000;
    localparam int CAL_LOW_CYCLES = (CAL_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAL_HIGH_CYCLES = (CAL_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Power-on wait and calibration lengths in sample-clock cycles
    // ------------------------------------------------------------
    localparam int POR_WAIT_SHORT_CYCLES = 8192;
    localparam int POR_WAIT_LONG_CYCLES = 65536;
    localparam int CAL_RUN_CYCLES = 16384;
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Calibration sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_START = 4'b0001,
        ST_POR_WAIT = 4'b0010,
        ST_IDLE = 4'b0100,
        ST_CAL = 4'b1000
    } cal_state_e;

endpackage

// >>> design/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);

    // ------------------------------------------------------------
    // Two-stage synchroniser per bit
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            logic meta;
            logic stable;
            // First stage feeds only the second stage
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    meta <= RESET_VAL[i];
                    stable <= RESET_VAL[i];
                end else begin
                    meta <= pin_in[i];
                    stable <= meta;
                end
            end
            assign pin_out[i] = stable;
        end
    endgenerate

endmodule

// >>> design/ref_delay_line.sv
`timescale 1ns/1ps
module ref_delay_line #(
    parameter int SEL_W = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ref_in,
    input wire logic [SEL_W-1:0] delay_sel,
    output logic ref_out
);

    localparam int DEPTH = 1 << SEL_W;

    logic [DEPTH-1:0] taps;
    logic [DEPTH-1:0] next_taps;
    logic next_ref_out;

    // ------------------------------------------------------------
    // Tap shift and selection
    // ------------------------------------------------------------
    // Whole-cycle steps only; finer steps would need the analog path
    always_comb begin
        next_taps = {taps[DEPTH-2:0], ref_in};
        next_ref_out = taps[delay_sel];
    end

    // Registered output so the selected tap never glitches downstream
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            taps <= '0;
            ref_out <= 1'b0;
        end else begin
            taps <= next_taps;
            ref_out <= next_ref_out;
        end
    end

endmodule

// >>> design/converter_mode_cal_control.sv
// Function
// [R01] Slave sync aligns divided clocks to reference input
// [R02] Reference input delay programmable in register mode
// [R03] Reference outputs run at sample clock over four
// [R04] Register bit enables reference outputs, default off
// [R05] Interleave pin high: channel one sampled twice
// [R06] Interleave pin low: channels convert independently
// [R07] Register mode takes interleave from register bit
// [R08] Wait select pin picks long or short wait
// [R09] Qualified low-then-high trigger starts one calibration
// [R10] Trigger high at power-on suppresses power-on calibration
// [R11] Register mode ORs trigger pin and command bit
// [R12] Running flag high exactly during calibration
// [R13] Enable pin low selects register control mode
// [R14] Calibration and wait lengths are cycle parameters
`timescale 1ns/1ps
module converter_mode_cal_control
    import converter_ctl_pkg::*;
#(
    parameter int POR_WAIT_SHORT = POR_WAIT_SHORT_CYCLES,
    parameter int POR_WAIT_LONG = POR_WAIT_LONG_CYCLES,
    parameter int CAL_RUN = CAL_RUN_CYCLES,
    parameter int CNT_W = 20,
    parameter int TRIG_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic extended_control_enable_n,
    input wire logic interleave_select_pin,
    input wire logic power_on_wait_select,
    input wire logic cal_trigger_pin,
    input wire logic ref_clock_in,
    input wire logic sync_enable,
    input wire logic sync_slave_mode,
    input wire logic [15:0] ctrl_reg,
    input wire logic [15:0] sync_reg,
    output logic register_control_mode,
    output logic registers_held_default,
    output logic interleave_active,
    output logic channel_two_convert,
    output logic divided_clock,
    output logic sync_ref_clock_out_a,
    output logic sync_ref_clock_out_b,
    output logic self_trim_active_flag
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic ece_n_s;
    logic ilv_pin_s;
    logic wait_sel_s;
    logic cal_pin_s;
    logic ref_in_s;

    // Enable pin resets high so the device wakes under pin control
    pin_sync #(
        .WIDTH(5),
        .RESET_VAL(5'h10)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_in({extended_control_enable_n, interleave_select_pin,
                 power_on_wait_select, cal_trigger_pin, ref_clock_in}),
        .pin_out({ece_n_s, ilv_pin_s, wait_sel_s, cal_pin_s, ref_in_s})
    );

    // ------------------------------------------------------------
    // Control mode and effective register contents
    // ------------------------------------------------------------
    logic reg_mode;
    logic [15:0] ctrl_eff;
    logic [15:0] sync_eff;

    // Pin mode forces defaults, so stale register bits never leak through
    always_comb begin
        reg_mode = ~ece_n_s;  // see [R13]
        ctrl_eff = reg_mode ? ctrl_reg : CTRL_DEFAULT;  // see [R13]
        sync_eff = reg_mode ? sync_reg : SYNC_DEFAULT;  // see [R13]
    end

    logic next_register_control_mode;
    logic next_registers_held_default;

    // Mode outputs
    always_comb begin
        next_register_control_mode = reg_mode;
        next_registers_held_default = ~reg_mode;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            register_control_mode <= 1'b0;
            registers_held_default <= 1'b1;
        end else begin
            register_control_mode <= next_register_control_mode;
            registers_held_default <= next_registers_held_default;
        end
    end

    // ------------------------------------------------------------
    // Reference input delay and edge detect
    // ------------------------------------------------------------
    logic ref_delayed;
    logic ref_delayed_q;
    logic next_ref_delayed_q;
    logic ref_rise;

    ref_delay_line #(
        .SEL_W(REF_DELAY_W)
    ) u_ref_delay (
        .clk_sys(clk_sys),
        .rst(rst),
        .ref_in(ref_in_s),
        .delay_sel(sync_eff[REF_DELAY_LSB +: REF_DELAY_W]),  // see [R02]
        .ref_out(ref_delayed)
    );

    // Edge detect works on the delayed copy, never on a sync stage
    always_comb begin
        next_ref_delayed_q = ref_delayed;
        ref_rise = ref_delayed & ~ref_delayed_q;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ref_delayed_q <= 1'b0;
        end else begin
            ref_delayed_q <= next_ref_delayed_q;
        end
    end

    // ------------------------------------------------------------
    // Divide-by-four clock and reference outputs
    // ------------------------------------------------------------
    logic [1:0] div_phase;
    logic [1:0] next_div_phase;
    logic next_divided_clock;
    logic next_ref_out;
    logic ref_out_en;

    // A slave snaps its phase to the reference edge; a master free-runs
    always_comb begin
        ref_out_en = sync_eff[REF_OUT_EN_BIT];  // see [R04]
        if (sync_enable && sync_slave_mode && ref_rise) begin
            next_div_phase = 2'h0;  // see [R01]
        end else begin
            next_div_phase = div_phase + 2'h1;  // see [R03]
        end
        next_divided_clock = next_div_phase[1];
        // Outputs run in master and slave alike, held low when disabled
        next_ref_out = ref_out_en & next_div_phase[1];  // see [R03] see [R04]
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div_phase <= 2'h0;
            divided_clock <= 1'b0;
            sync_ref_clock_out_a <= 1'b0;
            sync_ref_clock_out_b <= 1'b0;
        end else begin
            div_phase <= next_div_phase;
            divided_clock <= next_divided_clock;
            sync_ref_clock_out_a <= next_ref_out;
            sync_ref_clock_out_b <= next_ref_out;
        end
    end

    // ------------------------------------------------------------
    // Channel arrangement
    // ------------------------------------------------------------
    logic ilv_sel;
    logic next_interleave_active;
    logic next_channel_two_convert;

    // Register mode ignores the pin entirely
    always_comb begin
        if (reg_mode) begin
            ilv_sel = ctrl_eff[INTERLEAVE_BIT];  // see [R07]
        end else begin
            ilv_sel = ilv_pin_s;  // see [R05] see [R06]
        end
        next_interleave_active = ilv_sel;  // see [R05]
        // Second input is ignored while interleaved
        next_channel_two_convert = ~ilv_sel;  // see [R05] see [R06]
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            interleave_active <= 1'b0;
            channel_two_convert <= 1'b1;
        end else begin
            interleave_active <= next_interleave_active;
            channel_two_convert <= next_channel_two_convert;
        end
    end

    // ------------------------------------------------------------
    // Calibration trigger qualification
    // ------------------------------------------------------------
    logic trig;
    logic armed;
    logic next_armed;
    logic [TRIG_W-1:0] low_cnt;
    logic [TRIG_W-1:0] next_low_cnt;
    logic [TRIG_W-1:0] high_cnt;
    logic [TRIG_W-1:0] next_high_cnt;
    logic cal_request;

    localparam logic [TRIG_W-1:0] LOW_LIM = TRIG_W'(CAL_LOW_CYCLES);
    localparam logic [TRIG_W-1:0] HIGH_LIM = TRIG_W'(CAL_HIGH_CYCLES);

    // Arming needs one unbroken low stretch; a short low disarms again
    always_comb begin
        trig = cal_pin_s | (reg_mode & ctrl_eff[CAL_CMD_BIT]);  // see [R11]
        next_armed = armed;
        next_low_cnt = low_cnt;
        next_high_cnt = high_cnt;
        cal_request = 1'b0;
        if (!trig) begin
            next_high_cnt = '0;
            if (low_cnt != LOW_LIM) begin
                next_low_cnt = low_cnt + 1'b1;
            end
            next_armed = (next_low_cnt == LOW_LIM);  // see [R09]
        end else begin
            next_low_cnt = '0;
            if (armed) begin
                next_high_cnt = high_cnt + 1'b1;
                if (next_high_cnt == HIGH_LIM) begin
                    cal_request = 1'b1;  // see [R09]
                    next_armed = 1'b0;
                    next_high_cnt = '0;
                end
            end
        end
    end

    // Disarmed at reset, so a trigger already high needs a full cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            armed <= 1'b0;  // see [R10]
            low_cnt <= '0;
            high_cnt <= '0;
        end else begin
            armed <= next_armed;
            low_cnt <= next_low_cnt;
            high_cnt <= next_high_cnt;
        end
    end

    // ------------------------------------------------------------
    // Calibration sequencer
    // ------------------------------------------------------------
    cal_state_e state;
    cal_state_e next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [CNT_W-1:0] wait_lim;
    logic next_self_trim_active_flag;

    localparam logic [CNT_W-1:0] START_LIM = CNT_W'(SYNC_STAGES + 1);  // Second stage filled first
    localparam logic [CNT_W-1:0] SHORT_LIM = CNT_W'(POR_WAIT_SHORT);
    localparam logic [CNT_W-1:0] LONG_LIM = CNT_W'(POR_WAIT_LONG);
    localparam logic [CNT_W-1:0] RUN_LIM = CNT_W'(CAL_RUN);

    // Start waits for the synchronisers to fill before sampling the trigger
    always_comb begin
        wait_lim = wait_sel_s ? LONG_LIM : SHORT_LIM;  // see [R08] see [R14]
        next_state = state;
        next_cnt = cnt + 1'b1;
        unique case (state)
            ST_START: begin
                if (cnt + 1'b1 >= START_LIM) begin
                    next_cnt = '0;
                    if (trig) begin
                        next_state = ST_IDLE;  // see [R10]
                    end else begin
                        next_state = ST_POR_WAIT;
                    end
                end
            end
            ST_POR_WAIT: begin
                // A command during the wait starts calibration at once
                if (cal_request || (cnt + 1'b1 >= wait_lim)) begin
                    next_state = ST_CAL;  // see [R08]
                    next_cnt = '0;
                end
            end
            ST_IDLE: begin
                next_cnt = '0;
                if (cal_request) begin
                    next_state = ST_CAL;  // see [R09]
                end
            end
            ST_CAL: begin
                // Requests during a run are dropped, one run per command
                if (cnt + 1'b1 >= RUN_LIM) begin
                    next_state = ST_IDLE;  // see [R14]
                    next_cnt = '0;
                end
            end
        endcase
        next_self_trim_active_flag = (next_state == ST_CAL);  // see [R12]
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= ST_START;
            cnt <= '0;
            self_trim_active_flag <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            self_trim_active_flag <= next_self_trim_active_flag;
        end
    end

endmodule

// >>> testbench/converter_ctl_sva.sv
`timescale 1ns/1ps
module converter_ctl_sva #(
    parameter int CAL_RUN = 10
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:0] ctrl_reg,
    input wire logic [15:0] sync_reg,
    input wire logic sync_enable,
    input wire logic register_control_mode,
    input wire logic registers_held_default,
    input wire logic interleave_active,
    input wire logic channel_two_convert,
    input wire logic divided_clock,
    input wire logic sync_ref_clock_out_a,
    input wire logic sync_ref_clock_out_b,
    input wire logic self_trim_active_flag
);
    logic [15:0] run_len;
    logic [15:0] next_run_len;

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Cycles the flag has stood high so far, since a repetition cannot be that long
    always_comb begin
        next_run_len = (rst || !self_trim_active_flag) ? 16'h0000 : run_len + 16'h0001;
    end

    always_ff @(posedge clk_sys) begin
        run_len <= next_run_len;
    end

    // Calibration flag width, quarter-rate clocks and mode relations
    a_flag_run_len:
    assert property ($fell(self_trim_active_flag) |-> run_len == 16'(CAL_RUN))
        else $error("calibration flag too short");
    a_flag_not_long:
    assert property (self_trim_active_flag |-> run_len < 16'(CAL_RUN))
        else $error("calibration flag too long");
    a_ref_out_off:
    assert property (!register_control_mode || !$past(sync_reg[1]) |-> !sync_ref_clock_out_a)
        else $error("reference output active while disabled");
    a_ref_out_quarter:
    assert property ($rose(sync_ref_clock_out_a) && !sync_enable |=>
        sync_ref_clock_out_a ##1 !sync_ref_clock_out_a ##1 !sync_ref_clock_out_a)
        else $error("reference output not a quarter of the clock");
    a_div_quarter:
    assert property ($rose(divided_clock) && !sync_enable |=>
        divided_clock ##1 !divided_clock ##1 !divided_clock)
        else $error("divided clock not a quarter of the clock");
    a_ref_out_pair:
    assert property (sync_ref_clock_out_a == sync_ref_clock_out_b)
        else $error("reference outputs differ");
    a_interleave_reg:
    assert property (register_control_mode |-> interleave_active == $past(ctrl_reg[7]))
        else $error("interleave does not follow register bit");
    a_ch2_follow:
    assert property (channel_two_convert != interleave_active)
        else $error("second channel converts while interleaved");
    a_mode_inverse:
    assert property (registers_held_default != register_control_mode)
        else $error("default hold not inverse of register mode");
endmodule

// >>> testbench/host_partner.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host controller and upstream converter: trigger pin and reference
// ----------------------------------------------------------------
module host_partner (
    input wire logic clk_sys,
    output logic cal_trigger_pin = 1'b0,
    output logic ref_clock_in = 1'b0
);
    // Each level change lands just after a rising edge
    task automatic set_trig(input logic v);
        @(posedge clk_sys);
        cal_trigger_pin <= v;
    endtask

    task automatic ref_set(input logic v);
        @(posedge clk_sys);
        ref_clock_in <= v;
    endtask

    // Low for lo sampled edges, high for hi, then back low; short values model a careless host
    task automatic cal_pulse(input int lo, input int hi);
        set_trig(1'b0);
        repeat (lo - 1) @(posedge clk_sys);
        set_trig(1'b1);
        repeat (hi - 1) @(posedge clk_sys);
        set_trig(1'b0);
    endtask
endmodule

// >>> testbench/converter_mode_cal_control_tb_top.sv
`timescale 1ns/1ps
module converter_mode_cal_control_tb_top;
    import converter_ctl_pkg::*;
    localparam int P_RUN = 10;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ece_n;
    logic ilv_pin;
    logic wait_sel;
    logic s_en;
    logic s_slave;
    logic [15:0] ctrl;
    logic [15:0] sync;
    logic trig, ref_in, rcm, rhd, ilv, ch2, div, out_a, out_b, flag;
    int errors = 0;
    int samples_checked = 0;

    converter_mode_cal_control #(.POR_WAIT_SHORT(20), .POR_WAIT_LONG(40), .CAL_RUN(P_RUN)) DUT (
        .clk_sys(clk_sys), .rst(rst), .extended_control_enable_n(ece_n),
        .interleave_select_pin(ilv_pin), .power_on_wait_select(wait_sel),
        .cal_trigger_pin(trig), .ref_clock_in(ref_in), .sync_enable(s_en),
        .sync_slave_mode(s_slave), .ctrl_reg(ctrl), .sync_reg(sync),
        .register_control_mode(rcm), .registers_held_default(rhd),
        .interleave_active(ilv), .channel_two_convert(ch2), .divided_clock(div),
        .sync_ref_clock_out_a(out_a), .sync_ref_clock_out_b(out_b),
        .self_trim_active_flag(flag)
    );

    host_partner partner (.clk_sys(clk_sys), .cal_trigger_pin(trig), .ref_clock_in(ref_in));

    // ----------------------------------------------------------------
    // Clock, watchdog and shared tasks
    // ----------------------------------------------------------------
    initial begin
        forever #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
    end

    // A few thousand cycles is far beyond the whole sequence
    initial begin
        #(CLK_PERIOD_NS * 5000);
        errors++;
        test_done();
    end

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t value %0h, expected %0h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    function automatic logic pick(input int s);
        return (s == 0) ? flag : ((s == 1) ? out_a : ((s == 2) ? div : out_b));
    endfunction

    // Cycles out of n in which the chosen output is high, sampled mid-cycle
    task automatic count_high(input int s, input int n, output logic [15:0] k);
        k = 16'h0000;
        repeat (n) begin
            @(negedge clk_sys);
            if (pick(s) === 1'b1) k++;
        end
        // Hand back on a rising edge so the caller drives there
        @(posedge clk_sys);
    endtask

    // Cycles until a genuine low-to-high change of the chosen output, bounded
    task automatic rise_after(input int s, output logic [15:0] k);
        logic prev;
        prev = 1'b1;
        k = 16'h0000;
        for (int i = 0; i < 200; i++) begin
            @(negedge clk_sys);
            k++;
            if (!prev && pick(s) === 1'b1) break;
            prev = pick(s);
        end
        @(posedge clk_sys);
    endtask

    task automatic do_reset(input logic sel, input logic t);
        partner.set_trig(t);
        rst <= 1'b1;
        wait_sel <= sel;
        tick(3);
        rst <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_por(input logic sel, input int w);
        logic [15:0] k;
        do_reset(sel, 1'b0);
        rise_after(0, k);
        check(16'(k >= w && k <= w + 8), 16'h0001);
        count_high(0, 20, k);
        check(k, 16'(P_RUN - 1));
    endtask

    // Trigger held high through reset, then pulses above, at and just below the minimum times
    task automatic test_trigger();
        int lo [4] = '{25, 19, 20, 20};
        int hi [4] = '{20, 20, 19, 20};
        logic [15:0] k;
        do_reset(1'b0, 1'b1);
        count_high(0, 80, k);
        check(k, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            partner.set_trig(1'b1);
            partner.cal_pulse(lo[i], hi[i]);
            count_high(0, 30, k);
            check(k, (i == 0 || i == 3) ? 16'(P_RUN) : 16'h0000);
        end
    endtask

    task automatic reg_cal_try(input logic [15:0] exp);
        logic [15:0] k;
        ctrl[15] <= 1'b0;
        tick(25);
        ctrl[15] <= 1'b1;
        tick(20);
        ctrl[15] <= 1'b0;
        count_high(0, 30, k);
        check(k, exp);
    endtask

    // Command bit alone, pin alone, then bit masked by a pin already high
    task automatic test_reg_cal();
        logic [15:0] k;
        ece_n <= 1'b0;
        tick(5);
        reg_cal_try(16'(P_RUN));
        partner.set_trig(1'b1);
        count_high(0, 60, k);
        check(k, 16'(P_RUN));
        reg_cal_try(16'h0000);
        partner.set_trig(1'b0);
    endtask

    // Mode pin, interleave pin and interleave bit against the outputs
    task automatic test_modes();
        logic [3:0] cases [4] = '{4'hD, 4'hA, 4'h4, 4'h3};
        logic [3:0] c;
        for (int i = 0; i < 4; i++) begin
            c = cases[i];
            {ece_n, ilv_pin, ctrl[7]} <= c[3:1];
            tick(5);
            @(negedge clk_sys);
            check({rcm, ilv, ch2}, {~c[3], c[0], ~c[0]});
            check({rcm, rhd}, {~c[3], c[3]});
            @(posedge clk_sys);
        end
    endtask

    task automatic test_ref_out();
        logic [15:0] k;
        sync[1] <= 1'b1;
        tick(5);
        count_high(1, 16, k);
        check(k, 16'h0008);
        count_high(3, 16, k);
        check(k, 16'h0008);
        rise_after(1, k);
        ece_n <= 1'b1;
        tick(5);
        count_high(1, 16, k);
        check(k, 16'h0000);
        ece_n <= 1'b0;
        sync[1] <= 1'b0;
        tick(5);
        count_high(1, 16, k);
        check(k, 16'h0000);
    endtask

    task automatic align_phase(input int shift, output logic [15:0] k);
        partner.ref_set(1'b0);
        tick(10 + shift);
        partner.ref_set(1'b1);
        tick(12);
        rise_after(2, k);
        k = k % 16'h0004;
    endtask

    // Divided clock phase against reference rises, with and without slave alignment
    task automatic test_align();
        logic [15:0] a0, a1, a3;
        s_en <= 1'b1;
        s_slave <= 1'b1;
        align_phase(0, a0);
        align_phase(1, a1);
        check(a1, a0);
        sync[7:4] <= 4'h3;
        align_phase(0, a3);
        check(a3, (a0 + 16'h0003) % 16'h0004);
        s_slave <= 1'b0;
        align_phase(0, a0);
        align_phase(1, a1);
        check(16'(a1 != a0), 16'h0001);
        s_en <= 1'b0;
    endtask

    // Pin control, independent channels and outputs off to begin with
    initial begin
        ece_n <= 1'b1;
        ilv_pin <= 1'b0;
        wait_sel <= 1'b0;
        s_en <= 1'b0;
        s_slave <= 1'b0;
        ctrl <= 16'h0000;
        sync <= 16'h0000;
        test_por(1'b0, 20);
        test_por(1'b1, 40);
        test_trigger();
        test_reg_cal();
        test_modes();
        test_ref_out();
        test_align();
        test_done();
    end
endmodule

bind converter_mode_cal_control converter_ctl_sva #(.CAL_RUN(CAL_RUN)) u_sva (
    .clk_sys(clk_sys), .rst(rst), .ctrl_reg(ctrl_reg), .sync_reg(sync_reg),
    .sync_enable(sync_enable), .register_control_mode(register_control_mode),
    .registers_held_default(registers_held_default), .interleave_active(interleave_active),
    .channel_two_convert(channel_two_convert), .divided_clock(divided_clock),
    .sync_ref_clock_out_a(sync_ref_clock_out_a), .sync_ref_clock_out_b(sync_ref_clock_out_b),
    .self_trim_active_flag(self_trim_active_flag)
);
